// ### hw/ueds_defines.svh
// register indices, field positions, reset values and fixed addresses
// of the endpoint descriptor register bank; included by both design modules
`ifndef UEDS_DEFINES_SVH
`define UEDS_DEFINES_SVH

// register indices; byte address on the bus is four times the index
`define UEDS_IDX_IN0_CFG  16'hFF80
`define UEDS_IDX_IN0_CNT  16'hFF81
`define UEDS_IDX_OUT0_CFG 16'hFF82
`define UEDS_IDX_OUT0_CNT 16'hFF83
`define UEDS_IDX_YCNT     16'hFF84
`define UEDS_IDX_SIZE     16'hFF87
`define UEDS_IDX_STAT     16'hFF8A
`define UEDS_IDX_MASK     16'hFF8B

// field positions, shared by endpoint 0 and endpoints 1 to 3
`define UEDS_CFG_IE    2
`define UEDS_CFG_STALL 3
`define UEDS_CFG_TOG   5
`define UEDS_CFG_EN    7
`define UEDS_CNT_NAK   7

// software-writable bits of each register
`define UEDS_CFG_WMASK  8'h8C
`define UEDS_CNT0_WMASK 8'h8F
`define UEDS_SIZE_WMASK 8'h7F

// reset values
`define UEDS_IN0_CFG_RST  8'h00
`define UEDS_IN0_CNT_RST  8'h80
`define UEDS_OUT0_CFG_RST 8'h00
`define UEDS_OUT0_CNT_RST 8'h00
`define UEDS_YCNT_RST     8'h80
`define UEDS_SIZE_RST     8'h00

// fixed endpoint-0 buffer addresses and largest endpoint-0 packet
`define UEDS_EP0_IN_BASE  16'hFEF8
`define UEDS_EP0_OUT_BASE 16'hFEF0
`define UEDS_EP0_MAX      4'h8

// interrupt status bits
`define UEDS_ST_IN0   0
`define UEDS_ST_OUT0  1
`define UEDS_ST_SETUP 2
`define UEDS_ST_Y     3
`define UEDS_ST_W     6

`endif

// ### hw/ueds_pkg.sv
// types shared by the endpoint descriptor register bank
// assumes nothing of its surroundings
package ueds_pkg;

    // answer handed to the buffer manager for one token
    typedef enum logic [2:0] {
        UEDS_R_IDLE,
        UEDS_R_DATA,
        UEDS_R_NAK,
        UEDS_R_STALL,
        UEDS_R_XBUF
    } ueds_resp_t;

    // all state of the register bank
    typedef struct packed {
        logic             waitreq;
        logic [7:0]       rdata;
        logic [7:0]       in_cfg;
        logic [7:0]       in_cnt;
        logic [7:0]       out_cfg;
        logic [7:0]       out_cnt;
        logic [2:0][7:0]  ycnt;
        logic [2:0][7:0]  size;
        logic [5:0]       stat;
        logic [5:0]       mask;
        logic             irq;
        ueds_resp_t       resp;
        logic [6:0]       resp_cnt;
        logic [10:0]      resp_addr;
        logic             resp_vld;
    } ueds_st_t;

endpackage

// ### hw/ueds_ep0_resp.sv
// endpoint-0 answer decode from configuration and byte-count registers
// assumes register values stable; purely combinational
`timescale 1ns/10ps
`include "ueds_defines.svh"
module ueds_ep0_resp
    import ueds_pkg::*;
(
    input  wire logic [7:0] cfg,   // configuration register
    input  wire logic [7:0] cnt,   // byte-count register
    output ueds_resp_t      resp,  // answer kind
    output logic [3:0]      bytes  // usable byte count
);

    // reserved counts act as eight bytes
    assign bytes = (cnt[3:0] > `UEDS_EP0_MAX) ?
                   `UEDS_EP0_MAX : cnt[3:0];

    // disabled, stalled, busy, else serve
    always_comb
    begin
        if (!cfg[`UEDS_CFG_EN])
            resp = UEDS_R_IDLE;
        else if (cfg[`UEDS_CFG_STALL])
            resp = UEDS_R_STALL;
        else if (cnt[`UEDS_CNT_NAK])
            resp = UEDS_R_NAK;
        else
            resp = UEDS_R_DATA;
    end

endmodule // ueds_ep0_resp

// ### hw/ueds_regs.sv
// endpoint descriptor register bank of a full-speed usb function
// assumes an avalon-mm master and a buffer manager on ref_clk
// bus answers one cycle after a request, tokens one edge later
// firmware keeps counts and sizes at 64 or below
//
// Operation
// - y-buffer byte count of endpoints 1-3 is bits 6-0, 0 to 64.
// - y-count bit 7 set means empty and in tokens get nak.
// - endpoint 0 has four registers at consecutive indices.
// - endpoint 0 buffers sit at fixed addresses fef0 and fef8.
// - endpoint-0 fields share bit positions with endpoints 1-3.
// - bit 2 of an endpoint-0 config enables the completion irq.
// - config bit 3 forces stall, cleared by the next setup.
// - config bit 5 is read-only and shows the data toggle.
// - endpoint 0 is served only while config bit 7 is set.
// - endpoint-0 counts above eight are taken as eight.
// - endpoint-0 in count bit 7 set means empty, answer nak.
// - double buffering lets the toggle choose x or y buffer.
// - base fields are address bits 10-3 padded with zeros.
//
// The Avalon-MM register port is this design's own decision.
`timescale 1ns/10ps
`include "ueds_defines.svh"
module ueds_regs
    import ueds_pkg::*;
(
    input  wire logic             ref_clk,         // 20 mhz clock
    input  wire logic             rst,             // async reset
    input  wire logic [17:0]      avs_address,     // byte address
    input  wire logic             avs_read,        // read request
    input  wire logic             avs_write,       // write request
    input  wire logic [31:0]      avs_writedata,   // write data
    input  wire logic [3:0]       avs_byteenable,  // byte lanes
    output logic      [31:0]      avs_readdata,    // read data
    output logic                  avs_waitrequest, // stall master
    input  wire logic             mgr_tok,         // token pulse
    input  wire logic             mgr_tok_in,      // 1 in, 0 out
    input  wire logic [1:0]       mgr_tok_ep,      // token endpoint
    input  wire logic             mgr_done,        // done pulse
    input  wire logic             mgr_done_in,     // 1 in, 0 out
    input  wire logic [1:0]       mgr_done_ep,     // done endpoint
    input  wire logic [3:0]       mgr_done_cnt,    // out bytes taken
    input  wire logic             mgr_setup,       // setup pulse
    input  wire logic [2:0]       ep_double_buffer_en_en,      // double buffer
    input  wire logic [2:0]       ep_toggle,       // ep1-3 toggle
    input  wire logic [2:0][7:0]  ep_x_base,       // x base a10-a3
    input  wire logic [2:0][7:0]  ep_y_base,       // y base a10-a3
    output ueds_resp_t            mgr_resp,        // answer kind
    output logic      [6:0]       mgr_resp_cnt,    // bytes to send
    output logic      [10:0]      mgr_resp_addr,   // buffer start
    output logic                  mgr_resp_vld,    // answer pulse
    output logic                  irq              // level irq
);

    // state and its next value
    ueds_st_t    cur_r;
    ueds_st_t    nxt;

    // bus decode
    logic [15:0] idx;
    logic [2:0]  ycnt_hit;
    logic [2:0]  size_hit;
    logic [2:0]  use_y;

    // read and write data
    logic [7:0]  rd;
    logic [7:0]  wd;
    logic        wr_ok;

    // slot of ep1-3 events
    logic [1:0]  te;
    logic [1:0]  de;
    logic [5:0]  stat_ie;

    // endpoint-0 decode
    ueds_resp_t  in0_kind;
    ueds_resp_t  out0_kind;
    logic [3:0]  in0_bytes;
    logic [3:0]  out0_bytes;

    // fixed buffer starts
    logic [15:0] in0_base;
    logic [15:0] out0_base;

    // word index of the access
    assign idx = avs_address[17:2];
    assign wd  = avs_writedata[7:0];
    assign te  = 2'(mgr_tok_ep - 2'h1);
    assign de  = 2'(mgr_done_ep - 2'h1);

    // no base register for endpoint 0
    assign in0_base  = `UEDS_EP0_IN_BASE;
    assign out0_base = `UEDS_EP0_OUT_BASE;

    // per-endpoint decode and buffer choice
    genvar e;
    generate
        for (e = 0; e < 3; e = e + 1)
        begin : g_ep
            // count and size word of each slot
            assign ycnt_hit[e] = idx == (`UEDS_IDX_YCNT + 16'(e));
            assign size_hit[e] = idx == (`UEDS_IDX_SIZE + 16'(e));
            assign use_y[e]    = ep_double_buffer_en_en[e] & ep_toggle[e];
        end
    endgenerate

    // endpoint-0 answer decode, in and out
    ueds_ep0_resp u_in0
    (
        .cfg   (cur_r.in_cfg),
        .cnt   (cur_r.in_cnt),
        .resp  (in0_kind),
        .bytes (in0_bytes)
    );

    // same decode for the out direction
    ueds_ep0_resp u_out0
    (
        .cfg   (cur_r.out_cfg),
        .cnt   (cur_r.out_cnt),
        .resp  (out0_kind),
        .bytes (out0_bytes)
    );

    // read multiplexer
    // sampled into rdata in the wait cycle only
    always_comb
    begin
        rd = 8'h00;
        // endpoint 0 and interrupt words
        if (idx == `UEDS_IDX_IN0_CFG)
            rd = cur_r.in_cfg;
        else if (idx == `UEDS_IDX_IN0_CNT)
            rd = cur_r.in_cnt;
        else if (idx == `UEDS_IDX_OUT0_CFG)
            rd = cur_r.out_cfg;
        else if (idx == `UEDS_IDX_OUT0_CNT)
            rd = cur_r.out_cnt;
        else if (idx == `UEDS_IDX_STAT)
            rd = {2'h0, cur_r.stat};
        else if (idx == `UEDS_IDX_MASK)
            rd = {2'h0, cur_r.mask};
        else
        begin
            // ep1-3 words; unmapped reads zero
            for (int i = 0; i < 3; i++)
            begin
                if (ycnt_hit[i])
                    rd = cur_r.ycnt[i];
                if (size_hit[i])
                    rd = cur_r.size[i];
            end
        end
    end

    // next state: bus, setup, firmware writes, then other manager events
    always_comb
    begin
        nxt = cur_r;
        stat_ie = 6'h00;
        wr_ok = avs_write & ~cur_r.waitreq & avs_byteenable[0];

        // one wait cycle, then a single-cycle acknowledge
        // a request held past the ack starts anew
        nxt.waitreq = ~(cur_r.waitreq & (avs_read | avs_write));
        if (cur_r.waitreq & avs_read)
            nxt.rdata = rd;

        // setup clears both stalls; a same-cycle firmware set wins
        // toggles restart at one for the data stage
        if (mgr_setup)
        begin
            nxt.in_cfg[`UEDS_CFG_STALL]  = 1'b0;
            nxt.out_cfg[`UEDS_CFG_STALL] = 1'b0;
            nxt.in_cfg[`UEDS_CFG_TOG]    = 1'b1;
            nxt.out_cfg[`UEDS_CFG_TOG]   = 1'b1;
        end

        // firmware writes touch only writable bits
        // ep0 configs keep their toggle bit
        if (wr_ok)
        begin
            if (idx == `UEDS_IDX_IN0_CFG)
                nxt.in_cfg = (nxt.in_cfg & ~`UEDS_CFG_WMASK)
                           | (wd & `UEDS_CFG_WMASK);
            else if (idx == `UEDS_IDX_IN0_CNT)
                nxt.in_cnt = wd & `UEDS_CNT0_WMASK;
            else if (idx == `UEDS_IDX_OUT0_CFG)
                nxt.out_cfg = (nxt.out_cfg & ~`UEDS_CFG_WMASK)
                            | (wd & `UEDS_CFG_WMASK);
            else if (idx == `UEDS_IDX_OUT0_CNT)
                nxt.out_cnt = wd & `UEDS_CNT0_WMASK;
            else if (idx == `UEDS_IDX_STAT)
                // write one to clear
                nxt.stat = cur_r.stat & ~wd[5:0];
            else if (idx == `UEDS_IDX_MASK)
                nxt.mask = wd[5:0];
            else
            begin
                for (int i = 0; i < 3; i++)
                begin
                    if (ycnt_hit[i])
                        nxt.ycnt[i] = wd;
                    if (size_hit[i])
                        nxt.size[i] = wd & `UEDS_SIZE_WMASK;
                end
            end
        end

        // transaction done: buffer state, toggle, sticky events
        if (mgr_done)
        begin
            if (mgr_done_ep == 2'h0)
            begin
                if (mgr_done_in & cur_r.in_cfg[`UEDS_CFG_EN])
                begin
                    // buffer drained, back to firmware
                    nxt.in_cnt[`UEDS_CNT_NAK] = 1'b1;
                    nxt.in_cfg[`UEDS_CFG_TOG] =
                        ~cur_r.in_cfg[`UEDS_CFG_TOG];
                    stat_ie[`UEDS_ST_IN0] =
                        cur_r.in_cfg[`UEDS_CFG_IE];
                end
                else if (!mgr_done_in & cur_r.out_cfg[`UEDS_CFG_EN])
                begin
                    // keep the count received, mark full
                    nxt.out_cnt = {1'b1, 3'h0, mgr_done_cnt};
                    nxt.out_cfg[`UEDS_CFG_TOG] =
                        ~cur_r.out_cfg[`UEDS_CFG_TOG];
                    stat_ie[`UEDS_ST_OUT0] =
                        cur_r.out_cfg[`UEDS_CFG_IE];
                end
            end
            else if (mgr_done_in & use_y[de])
            begin
                // y buffer sent, firmware refills it
                nxt.ycnt[de][`UEDS_CNT_NAK] = 1'b1;
                stat_ie[`UEDS_ST_Y + 32'(de)] = 1'b1;
            end
        end

        // every setup is recorded
        stat_ie[`UEDS_ST_SETUP] = mgr_setup;

        // events win over a same-cycle clear
        // irq uses next state, so it moves with stat
        nxt.stat = nxt.stat | stat_ie;
        nxt.irq  = |(nxt.stat & nxt.mask);

        // token answer, one cycle after the token
        nxt.resp_vld = mgr_tok;
        if (mgr_tok)
        begin
            nxt.resp      = UEDS_R_IDLE;
            nxt.resp_cnt  = 7'h00;
            nxt.resp_addr = 11'h000;

            // ep1-3 out tokens are not ours: idle
            if (mgr_tok_ep == 2'h0)
            begin
                if (mgr_tok_in)
                begin
                    // fixed start, clamped count
                    nxt.resp      = in0_kind;
                    nxt.resp_cnt  = {3'h0, in0_bytes};
                    nxt.resp_addr = in0_base[10:0];
                end
                else
                begin
                    // out answers use the out registers
                    nxt.resp      = out0_kind;
                    nxt.resp_cnt  = {3'h0, out0_bytes};
                    nxt.resp_addr = out0_base[10:0];
                end
            end
            else if (mgr_tok_in)
            begin
                if (use_y[te])
                begin
                    nxt.resp = cur_r.ycnt[te][`UEDS_CNT_NAK] ?
                               UEDS_R_NAK : UEDS_R_DATA;
                    nxt.resp_cnt  = cur_r.ycnt[te][6:0];
                    nxt.resp_addr = {ep_y_base[te], 3'h0};
                end
                else
                begin
                    // x buffer served elsewhere, start only
                    nxt.resp      = UEDS_R_XBUF;
                    nxt.resp_addr = {ep_x_base[te], 3'h0};
                end
            end
        end
    end

    // state register
    always_ff @(posedge ref_clk or posedge rst)
    begin
        // in and y counts come up not ready, waitrequest high, all else clear
        if (rst)
        begin
            cur_r.waitreq   <= 1'b1;
            cur_r.rdata     <= 8'h00;
            cur_r.in_cfg    <= `UEDS_IN0_CFG_RST;
            cur_r.in_cnt    <= `UEDS_IN0_CNT_RST;
            cur_r.out_cfg   <= `UEDS_OUT0_CFG_RST;
            cur_r.out_cnt   <= `UEDS_OUT0_CNT_RST;
            cur_r.ycnt      <= {3{`UEDS_YCNT_RST}};
            cur_r.size      <= {3{`UEDS_SIZE_RST}};

            // events, mask and interrupt
            cur_r.stat      <= 6'h00;
            cur_r.mask      <= 6'h00;
            cur_r.irq       <= 1'b0;

            // no answer pending
            cur_r.resp      <= UEDS_R_IDLE;
            cur_r.resp_cnt  <= 7'h00;
            cur_r.resp_addr <= 11'h000;
            cur_r.resp_vld  <= 1'b0;
        end
        else
        begin
            // whole state moves in one step
            cur_r <= nxt;
        end
    end

    // bus outputs straight from the state register
    assign avs_readdata    = {24'h000000, cur_r.rdata};
    assign avs_waitrequest = cur_r.waitreq;

    // token answer, registered
    assign mgr_resp        = cur_r.resp;
    assign mgr_resp_cnt    = cur_r.resp_cnt;
    assign mgr_resp_addr   = cur_r.resp_addr;
    assign mgr_resp_vld    = cur_r.resp_vld;

    // level interrupt, registered
    assign irq             = cur_r.irq;

endmodule // ueds_regs

// ### tb/ueds_chk.sv
// port checker of the endpoint descriptor register bank
// assumes it is bound onto ueds_regs, one clock domain
`timescale 1ns/10ps
module ueds_chk
    import ueds_pkg::*;
(
    input  wire logic            ref_clk,         // clock
    input  wire logic            rst,             // async reset
    input  wire logic            avs_read,        // read request
    input  wire logic            avs_write,       // write request
    input  wire logic [31:0]     avs_readdata,    // read data
    input  wire logic            avs_waitrequest, // stall
    input  wire logic            mgr_tok,         // token pulse
    input  wire logic            mgr_tok_in,      // token direction
    input  wire logic [1:0]      mgr_tok_ep,      // token endpoint
    input  wire logic            mgr_done,        // done pulse
    input  wire logic            mgr_setup,       // setup pulse
    input  wire logic [2:0]      ep_double_buffer_en_en,      // double buffer
    input  wire logic [2:0]      ep_toggle,       // toggles
    input  wire logic [2:0][7:0] ep_x_base,       // x bases
    input  wire logic [2:0][7:0] ep_y_base,       // y bases
    input  wire ueds_resp_t      mgr_resp,        // answer kind
    input  wire logic [6:0]      mgr_resp_cnt,    // answer count
    input  wire logic [10:0]     mgr_resp_addr,   // answer start
    input  wire logic            mgr_resp_vld,    // answer pulse
    input  wire logic            irq              // interrupt
);
    logic [1:0]  sel;
    logic        ysel;
    logic [10:0] y_exp_r;
    logic [10:0] x_exp_r;
    logic [2:0]  quiet_r;

    // endpoint 1-3 slot of the token and its buffer choice
    assign sel = mgr_tok_ep - 2'd1;
    assign ysel = ep_double_buffer_en_en[sel] & ep_toggle[sel];

    // expected buffer starts, one cycle behind the token
    always_ff @(posedge ref_clk)
    begin
        y_exp_r <= {ep_y_base[sel], 3'b000};
        x_exp_r <= {ep_x_base[sel], 3'b000};
    end

    // cycles since anything that may raise the interrupt
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            quiet_r <= 3'h7;
        else if (mgr_done || mgr_setup || avs_write)
            quiet_r <= 3'h0;
        else if (quiet_r != 3'h7)
            quiet_r <= quiet_r + 3'h1;
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    property p_ack; (avs_read || avs_write) && avs_waitrequest
        |=> !avs_waitrequest; endproperty
    a_ack: assert property (p_ack) else $error("no bus answer");
    property p_ack_one; !avs_waitrequest |=> avs_waitrequest; endproperty
    a_ack_one: assert property (p_ack_one) else $error("long ack");
    property p_rd_hi; !avs_waitrequest |-> avs_readdata[31:8] == 24'h0;
    endproperty
    a_rd_hi: assert property (p_rd_hi) else $error("upper data");
    property p_vld; mgr_tok |=> mgr_resp_vld; endproperty
    a_vld: assert property (p_vld) else $error("no answer");
    property p_vld_cause; mgr_resp_vld |-> $past(mgr_tok); endproperty
    a_vld_cause: assert property (p_vld_cause) else $error("stray");
    property p_ep0_in; mgr_tok && mgr_tok_in && mgr_tok_ep == 2'd0
        |=> mgr_resp == UEDS_R_IDLE
        || (mgr_resp_addr == 11'h6F8 && mgr_resp_cnt <= 7'd8); endproperty
    a_ep0_in: assert property (p_ep0_in) else $error("ep0 in");
    property p_ep0_out; mgr_tok && !mgr_tok_in && mgr_tok_ep == 2'd0
        |=> mgr_resp == UEDS_R_IDLE || mgr_resp_addr == 11'h6F0; endproperty
    a_ep0_out: assert property (p_ep0_out) else $error("ep0 out");
    property p_ybuf; mgr_tok && mgr_tok_in && mgr_tok_ep != 2'd0 && ysel
        |=> mgr_resp_addr == y_exp_r
        && mgr_resp inside {UEDS_R_DATA, UEDS_R_NAK}; endproperty
    a_ybuf: assert property (p_ybuf) else $error("y buffer");
    property p_xbuf; mgr_tok && mgr_tok_in && mgr_tok_ep != 2'd0 && !ysel
        |=> mgr_resp == UEDS_R_XBUF && mgr_resp_addr == x_exp_r; endproperty
    a_xbuf: assert property (p_xbuf) else $error("x buffer");
    property p_out13; mgr_tok && !mgr_tok_in && mgr_tok_ep != 2'd0
        |=> mgr_resp == UEDS_R_IDLE; endproperty
    a_out13: assert property (p_out13) else $error("out ep1-3");
    property p_irq; $rose(irq) |-> quiet_r < 3'h4; endproperty
    a_irq: assert property (p_irq) else $error("irq no cause");
endmodule // ueds_chk

bind ueds_regs ueds_chk ueds_chk_i (.ref_clk, .rst, .avs_read, .avs_write,
    .avs_readdata, .avs_waitrequest, .mgr_tok, .mgr_tok_in, .mgr_tok_ep,
    .mgr_done, .mgr_setup, .ep_double_buffer_en_en, .ep_toggle, .ep_x_base,
    .ep_y_base, .mgr_resp, .mgr_resp_cnt, .mgr_resp_addr, .mgr_resp_vld,
    .irq);

// ### tb/ueds_mgr_model.sv
// buffer manager model: tokens, completions and setup pulses
// assumes the bench calls one task at a time
`timescale 1ns/10ps
module ueds_mgr_model
(
    input  wire logic       ref_clk,      // clock
    output logic            mgr_tok,      // token pulse
    output logic            mgr_tok_in,   // token direction
    output logic      [1:0] mgr_tok_ep,   // token endpoint
    output logic            mgr_done,     // done pulse
    output logic            mgr_done_in,  // done direction
    output logic      [1:0] mgr_done_ep,  // done endpoint
    output logic      [3:0] mgr_done_cnt, // out bytes taken
    output logic            mgr_setup     // setup pulse
);
    // quiet at time zero
    initial
    begin
        {mgr_tok, mgr_tok_in, mgr_tok_ep} = 4'h0;
        {mgr_done, mgr_done_in, mgr_done_ep, mgr_done_cnt} = 8'h00;
        mgr_setup = 1'b0;
    end

    // one token; qualifiers inverted afterwards, never left stale
    task automatic tok(input logic in, input logic [1:0] ep);
        @(posedge ref_clk);
        {mgr_tok, mgr_tok_in, mgr_tok_ep} <= {1'b1, in, ep};
        @(posedge ref_clk);
        {mgr_tok, mgr_tok_in, mgr_tok_ep} <= {1'b0, ~in, ~ep};
    endtask

    // one completion
    task automatic done(input logic in, input logic [1:0] ep);
        @(posedge ref_clk);
        {mgr_done, mgr_done_in, mgr_done_ep} <= {1'b1, in, ep};
        mgr_done_cnt <= 4'h5;
        @(posedge ref_clk);
        {mgr_done, mgr_done_in, mgr_done_ep} <= {1'b0, ~in, ~ep};
        mgr_done_cnt <= 4'hA;
    endtask

    // one setup arrival
    task automatic setup();
        @(posedge ref_clk);
        mgr_setup <= 1'b1;
        @(posedge ref_clk);
        mgr_setup <= 1'b0;
    endtask
endmodule // ueds_mgr_model

// ### tb/usb_endpoint_descriptor_regs_tb.sv
// self-checking bench of the endpoint descriptor register bank
// assumes the manager model and the checker are compiled first
`timescale 1ns/10ps
module usb_endpoint_descriptor_regs_tb
    import ueds_pkg::*;
;
    logic            ref_clk, rst, avs_read, avs_write, irq;
    logic            avs_waitrequest, mgr_resp_vld;
    logic [17:0]     avs_address;
    logic [31:0]     avs_writedata, avs_readdata;
    logic            mgr_tok, mgr_tok_in, mgr_done, mgr_done_in, mgr_setup;
    logic [1:0]      mgr_tok_ep, mgr_done_ep;
    logic [3:0]      mgr_done_cnt;
    logic [2:0]      ep_double_buffer_en_en, ep_toggle;
    logic [2:0][7:0] ep_x_base, ep_y_base;
    ueds_resp_t      mgr_resp;
    logic [6:0]      mgr_resp_cnt;
    logic [10:0]     mgr_resp_addr;
    logic [7:0]      rd;
    int              n_fail, checks_done;

    ueds_regs ueds_regs_i (.ref_clk, .rst, .avs_address, .avs_read,
        .avs_write, .avs_writedata, .avs_byteenable(4'h1), .avs_readdata,
        .avs_waitrequest, .mgr_tok, .mgr_tok_in, .mgr_tok_ep, .mgr_done,
        .mgr_done_in, .mgr_done_ep, .mgr_done_cnt, .mgr_setup, .ep_double_buffer_en_en,
        .ep_toggle, .ep_x_base, .ep_y_base, .mgr_resp, .mgr_resp_cnt,
        .mgr_resp_addr, .mgr_resp_vld, .irq);
    ueds_mgr_model mgr_i (.ref_clk, .mgr_tok, .mgr_tok_in, .mgr_tok_ep,
        .mgr_done, .mgr_done_in, .mgr_done_ep, .mgr_done_cnt, .mgr_setup);

    // 20 mhz clock
    initial
    begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    // compare and count
    task automatic chk(input string nm, input logic [10:0] exp,
                       input logic [10:0] got);
        checks_done++;
        if (got !== exp)
        begin
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
            n_fail++;
        end
    endtask

    // one avalon transfer, held until waitrequest is sampled low
    task automatic xfer(input logic wr, input logic [15:0] idx,
                        input logic [7:0] wd);
        int n;
        @(posedge ref_clk);
        avs_address <= {idx, 2'b00};
        {avs_read, avs_write} <= {~wr, wr};
        avs_writedata <= {24'h0, wd};
        n = 0;
        do
        begin
            @(posedge ref_clk);
            n++;
        end
        while (avs_waitrequest !== 1'b0 && n < 100);
        if (n >= 100)
            chk("waitrequest", 11'h0, {10'h0, avs_waitrequest});
        rd = avs_readdata[7:0];
        {avs_read, avs_write} <= 2'b00;
    endtask

    // read and compare one register
    task automatic rdc(input logic [15:0] idx, input logic [7:0] exp);
        xfer(1'b0, idx, 8'h00);
        chk($sformatf("reg %h", idx), {3'b000, exp}, {3'b000, rd});
    endtask

    // token and its answer one edge later
    task automatic tokc(input logic in, input logic [1:0] ep,
                        input ueds_resp_t r, input logic [6:0] c,
                        input logic [10:0] a);
        mgr_i.tok(in, ep);
        #1;
        chk("vld", 11'h1, {10'h0, mgr_resp_vld});
        chk("resp", {8'h0, r}, {8'h0, mgr_resp});
        if (r inside {UEDS_R_DATA, UEDS_R_XBUF})
        begin
            chk("cnt", {4'h0, c}, {4'h0, mgr_resp_cnt});
            chk("addr", a, mgr_resp_addr);
        end
    endtask

    // irq level one edge on
    task automatic irqc(input logic exp);
        @(posedge ref_clk);
        #1;
        chk("irq", {10'h0, exp}, {10'h0, irq});
    endtask

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // hang guard, far beyond the few hundred cycles of the tests
    initial
    begin
        #500_000;
        n_fail++;
        wrap_up();
    end

    // tests
    initial
    begin
        {rst, avs_read, avs_write, avs_address, avs_writedata} = 53'h1 << 52;
        {ep_double_buffer_en_en, ep_toggle} = 6'h00;
        ep_x_base = {8'h93, 8'h92, 8'h91};
        ep_y_base = {8'hC3, 8'hC2, 8'hC1};
        repeat (16) @(posedge ref_clk);
        rst <= 1'b0;
        for (int i = 0; i < 12; i++)
            rdc(16'hFF80 + 16'(i),
                (i == 1 || (i > 3 && i < 7)) ? 8'h80 : 8'h00);
        $display("test reset values done");
        xfer(1'b1, 16'hFF80, 8'hFF);
        rdc(16'hFF80, 8'h8C);
        xfer(1'b1, 16'hFF81, 8'hFF);
        rdc(16'hFF81, 8'h8F);
        xfer(1'b1, 16'hFF87, 8'hFF);
        rdc(16'hFF87, 8'h7F);
        xfer(1'b1, 16'hFF84, 8'hFF);
        rdc(16'hFF84, 8'hFF);
        xfer(1'b1, 16'hFF90, 8'h5A);
        rdc(16'hFF90, 8'h00);
        $display("test access kinds done");
        xfer(1'b1, 16'hFF80, 8'h00);
        xfer(1'b1, 16'hFF81, 8'h83);
        xfer(1'b1, 16'hFF81, 8'h03);
        tokc(1'b1, 2'd0, UEDS_R_IDLE, 7'h0, 11'h0);
        xfer(1'b1, 16'hFF80, 8'h80);
        tokc(1'b1, 2'd0, UEDS_R_DATA, 7'h3, 11'h6F8);
        xfer(1'b1, 16'hFF81, 8'h8F);
        tokc(1'b1, 2'd0, UEDS_R_NAK, 7'h0, 11'h0);
        xfer(1'b1, 16'hFF81, 8'h0F);
        tokc(1'b1, 2'd0, UEDS_R_DATA, 7'h8, 11'h6F8);
        xfer(1'b1, 16'hFF80, 8'h88);
        tokc(1'b1, 2'd0, UEDS_R_STALL, 7'h0, 11'h0);
        mgr_i.setup();
        rdc(16'hFF80, 8'hA0);
        xfer(1'b1, 16'hFF82, 8'h80);
        mgr_i.tok(1'b0, 2'd0);
        mgr_i.tok(1'b0, 2'd1);
        mgr_i.done(1'b0, 2'd0);
        rdc(16'hFF83, 8'h85);
        $display("test endpoint zero done");
        xfer(1'b1, 16'hFF80, 8'h84);
        mgr_i.done(1'b1, 2'd0);
        irqc(1'b0);
        rdc(16'hFF81, 8'h8F);
        rdc(16'hFF80, 8'h84);
        rdc(16'hFF8A, 8'h05);
        xfer(1'b1, 16'hFF8B, 8'h01);
        irqc(1'b1);
        xfer(1'b1, 16'hFF8A, 8'h05);
        irqc(1'b0);
        xfer(1'b1, 16'hFF80, 8'h80);
        mgr_i.done(1'b1, 2'd0);
        rdc(16'hFF8A, 8'h00);
        $display("test interrupt done");
        {ep_double_buffer_en_en, ep_toggle} <= 6'h3F;
        for (int e = 1; e < 4; e++)
        begin
            xfer(1'b1, 16'hFF83 + 16'(e), 8'h40);
            tokc(1'b1, 2'(e), UEDS_R_DATA, 7'h40,
                 {ep_y_base[e-1], 3'b000});
            mgr_i.done(1'b1, 2'(e));
            rdc(16'hFF83 + 16'(e), 8'hC0);
            tokc(1'b1, 2'(e), UEDS_R_NAK, 7'h0, 11'h0);
        end
        rdc(16'hFF8A, 8'h38);
        ep_toggle <= 3'h0;
        tokc(1'b1, 2'd1, UEDS_R_XBUF, 7'h0, {ep_x_base[0], 3'b000});
        $display("test y buffers done");
        wrap_up();
    end
endmodule // usb_endpoint_descriptor_regs_tb
